// ==== tb/ssw_host.sv ====
// Purpose: host controller model on the reset and kick pins
// Assumes: kicks stop only when the bench asks
// Notes: pulls the reset wire only while press is high
`timescale 1ns/1ns
module ssw_host #(
    parameter int KICK_CYC = 60
) (
    // controls
    input wire logic clk,
    input wire logic kick_en,
    input wire logic press,
    // pins
    output logic kick,
    output logic pull
);
    int cnt = 0;
    initial kick = 1'b0;
    always @(posedge clk) begin
        #1;
        cnt = kick_en ? cnt + 1 : 0;
        if (cnt >= KICK_CYC) begin
            kick = ~kick;
            cnt = 0;
        end
    end
    assign pull = press;
endmodule : ssw_host

// ==== tb/ssw_props.sv ====
// Purpose: port assertions for the supervisor
// Assumes: one clock, sync active-low reset
// Notes: margins cover the input synchronisers
`timescale 1ns/1ns
module ssw_props
    import ssw_pkg::*;
#(
    parameter bit DUAL_RESET = 1'b1,
    parameter bit HAS_WDT = 1'b0,
    parameter int unsigned P_RST_TIMEOUT_CYC = 50,
    parameter int unsigned P_WDT_CYC = 80,
    parameter int unsigned P_WRITE_CYCLE_CYC = 40
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pins in
    input wire logic vcc_below_th,
    input wire logic aux_below_ref,
    input wire logic reset_n_pin_i,
    input wire logic watchdog_kick_input,
    // outputs
    input wire logic reset_n_pin_oe,
    input wire logic reset_hi_o,
    input wire logic aux_low_voltage_output_oe,
    input wire logic bus_busy,
    input wire logic wr_blocked
);
    int oe_q, oe_d, bz_q, bz_d, qt_q, qt_d;
    logic kick_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    always_comb begin
        oe_d = reset_n_pin_oe ? oe_q + 1 : 0;
        bz_d = bus_busy ? bz_q + 1 : 0;
        // raw pin edge; the design lags it by its synchroniser
        qt_d = (reset_n_pin_oe || kick_q != watchdog_kick_input)
            ? 0 : qt_q + 1;
    end
    always_ff @(posedge clk) begin
        oe_q <= nrst ? oe_d : 0;
        bz_q <= nrst ? bz_d : 0;
        qt_q <= nrst ? qt_d : 0;
        kick_q <= watchdog_kick_input;
    end
    chk_vcc_hold: assert property (vcc_below_th[*4] |-> reset_n_pin_oe)
        else $error("reset not held while supply low");
    chk_dual_match: assert property (
        reset_hi_o == (DUAL_RESET && reset_n_pin_oe))
        else $error("reset outputs disagree");
    chk_timeout_len: assert property (
        $fell(reset_n_pin_oe) |-> oe_q >= P_RST_TIMEOUT_CYC)
        else $error("reset released early");
    chk_wr_block: assert property (vcc_below_th[*4] |-> wr_blocked)
        else $error("writes not blocked");
    chk_aux_follow: assert property (
        $stable(aux_below_ref)[*4]
        |-> aux_low_voltage_output_oe == aux_below_ref)
        else $error("aux output wrong");
    chk_manual_start: assert property (
        (!reset_n_pin_oe && reset_n_pin_i)[*4] ##1 (!reset_n_pin_i)[*3]
        |-> ##1 reset_n_pin_oe)
        else $error("manual reset missed");
    chk_busy_len: assert property (
        $fell(bus_busy) |-> bz_q == P_WRITE_CYCLE_CYC)
        else $error("program cycle length wrong");
    chk_wdt_bound: assert property (
        HAS_WDT |-> qt_q <= P_WDT_CYC + 6)
        else $error("watchdog did not expire");
    cover property ($fell(reset_n_pin_oe));
    cover property ($rose(bus_busy));
    cover property ($rose(aux_low_voltage_output_oe));
endmodule : ssw_props
bind ssw_supervisor ssw_props #(.DUAL_RESET(DUAL_RESET), .HAS_WDT(HAS_WDT),
    .P_RST_TIMEOUT_CYC(P_RST_TIMEOUT_CYC), .P_WDT_CYC(P_WDT_CYC),
    .P_WRITE_CYCLE_CYC(P_WRITE_CYCLE_CYC)) u_props (.clk, .nrst, .vcc_below_th,
    .aux_below_ref, .reset_n_pin_i, .watchdog_kick_input, .reset_n_pin_oe,
    .reset_hi_o, .aux_low_voltage_output_oe, .bus_busy, .wr_blocked);

// ==== tb/ssw_supervisor_tb_top.sv ====
// Purpose: self-checking bench for the supervisor
// Assumes: shortened counts, host model on kick and reset pin
// Notes: reset pin is a pulled-up wire resolved here
`timescale 1ns/1ns
module ssw_supervisor_tb_top
    import ssw_pkg::*;
;
    localparam int PR = 50;
    localparam int PW = 80;
    logic clk, nrst, vcc, aux, kick_en, press, pull, kick, pin_oe, pin_o, hi;
    logic aux_oe, aux_o, wr_begin, wr_stop, busy, blk;
    logic [7:0] wr_addr;
    ssw_byte_t wr_byte;
    ssw_array_wr_t aw;
    ssw_array_wr_t wq[$];
    int n_mismatch, checks_done, cyc, n;
    logic lo_oe, lo_hi;
    wire pin = !(pin_oe || pull);
    wire lo_pin = !(lo_oe || pull);
    ssw_supervisor #(.HAS_WDT(1'b1), .P_RST_TIMEOUT_CYC(PR), .P_WDT_CYC(PW),
        .P_WRITE_CYCLE_CYC(40)) dut (.clk, .nrst, .vcc_below_th(vcc),
        .aux_below_ref(aux), .reset_n_pin_i(pin), .reset_n_pin_o(pin_o),
        .reset_n_pin_oe(pin_oe), .reset_hi_o(hi), .watchdog_kick_input(kick),
        .aux_low_voltage_output_o(aux_o), .aux_low_voltage_output_oe(aux_oe),
        .wr_begin, .wr_addr, .wr_byte, .wr_stop, .bus_busy(busy),
        .wr_blocked(blk), .array_wr(aw));
    // single-output variant on the same stimulus
    ssw_supervisor #(.DUAL_RESET(1'b0), .HAS_WDT(1'b1),
        .P_RST_TIMEOUT_CYC(PR), .P_WDT_CYC(PW), .P_WRITE_CYCLE_CYC(40))
        dut_lo (.clk, .nrst, .vcc_below_th(vcc), .aux_below_ref(aux),
        .reset_n_pin_i(lo_pin), .reset_n_pin_o(), .reset_n_pin_oe(lo_oe),
        .reset_hi_o(lo_hi), .watchdog_kick_input(kick),
        .aux_low_voltage_output_o(), .aux_low_voltage_output_oe(),
        .wr_begin, .wr_addr, .wr_byte, .wr_stop, .bus_busy(),
        .wr_blocked(), .array_wr());
    ssw_host #(.KICK_CYC(60)) host (.clk, .kick_en, .press, .kick, .pull);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (aw.we === 1'b1) wq.push_back(aw);
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task step(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wait_oe(input logic lvl);
        for (n = 0; pin_oe !== lvl && n < 300; n++) step();
    endtask : wait_oe
    task wr_seq(input logic [7:0] a, input int nb);
        wr_begin = 1'b1;
        wr_addr = a;
        step();
        wr_begin = 1'b0;
        for (int i = 0; i < nb; i++) begin
            wr_byte = '{1'b1, 8'ha0 + i[7:0]};
            step();
        end
        wr_byte = '0;
        wr_stop = 1'b1;
        step();
        wr_stop = 1'b0;
    endtask : wr_seq
    task t_power;
        wr_seq(8'h10, 2);
        step(5);
        chk("blocked writes", 8'h0, 8'(wq.size()));
        chk("reset pin", 8'h1, pin_oe);
        chk("reset high", 8'h1, hi);
        chk("pin levels", 8'h0, {pin_o, aux_o});
        chk("wr blocked", 8'h1, blk);
        chk("single variant", 8'h2, {lo_oe, lo_hi});
        vcc = 1'b0;
        wait_oe(1'b0);
        chk("timeout", 8'h1, n >= PR && n <= PR + 4);
        chk("reset high off", 8'h0, hi);
        chk("wr open", 8'h0, blk);
        chk("single variant off", 8'h0, {lo_oe, lo_hi});
    endtask : t_power
    task t_aux;
        aux = 1'b1;
        step(4);
        chk("aux low", 8'h1, aux_oe);
        aux = 1'b0;
        step(4);
        chk("aux high", 8'h0, aux_oe);
    endtask : t_aux
    task t_write;
        wr_seq(8'h2e, 3);
        step();
        chk("busy", 8'h1, busy);
        wr_seq(8'h50, 1);
        for (n = 0; busy !== 1'b0 && n < 100; n++) step();
        chk("write count", 8'h3, 8'(wq.size()));
        foreach (wq[i]) begin
            chk("addr", {4'h2, 4'he + i[3:0]}, wq[i].addr);
            chk("data", 8'ha0 + i[7:0], wq[i].data);
        end
    endtask : t_write
    task t_manual;
        press = 1'b1;
        step(4);
        chk("manual", 8'h1, pin_oe);
        press = 1'b0;
        wait_oe(1'b0);
        chk("manual timeout", 8'h1, n >= PR - 4 && n <= PR + 4);
    endtask : t_manual
    task t_wdt;
        step(200);
        chk("kicked", 8'h0, pin_oe);
        @(kick);
        kick_en = 1'b0;
        wait_oe(1'b1);
        chk("expiry", 8'h1, n >= PW && n <= PW + 8);
        kick_en = 1'b1;
        wait_oe(1'b0);
        chk("wdt timeout", 8'h1, n >= PR - 2 && n <= PR + 2);
        kick_en = 1'b0;
        wait_oe(1'b1);
        chk("fresh interval", 8'h1, n >= PW && n <= PW + 2);
        kick_en = 1'b1;
        wait_oe(1'b0);
        chk("last timeout", 8'h1, n >= PR - 2 && n <= PR + 2);
    endtask : t_wdt
    task end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        {nrst, aux, press, wr_begin, wr_stop, wr_addr, wr_byte} = '0;
        {vcc, kick_en, n_mismatch, checks_done, cyc} = {2'h3, 96'h0};
        step(20);
        nrst = 1'b1;
        t_power();
        t_aux();
        t_write();
        t_manual();
        t_wdt();
        end_sim();
    end
endmodule : ssw_supervisor_tb_top

// ==== verilog/ssw_page_buf.sv ====
// Purpose: page write buffer storage
// Assumes: single clock, one write and one read port
// Notes: read data is registered, one cycle latency
`timescale 1ns/1ns
module ssw_page_buf
    import ssw_pkg::*;
(
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [PAGE_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // read port
    input wire logic [PAGE_AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [PAGE_BYTES];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : ssw_page_buf

// ==== verilog/ssw_pkg.sv ====
// Purpose: shared constants and types for the supply supervisor block
// Assumes: 100 MHz clock, synchronous active-low reset
// Notes: cycle counts derive from the printed times and the clock rate
package ssw_pkg;
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned T_RST_TIMEOUT_MS = 200;
    localparam int unsigned T_WDT_MS = 1600;
    localparam int unsigned T_WRITE_CYCLE_MS = 5;
    localparam int unsigned RST_TIMEOUT_CYC = T_RST_TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned WDT_CYC = T_WDT_MS * CLK_KHZ;
    localparam int unsigned WRITE_CYCLE_CYC = T_WRITE_CYCLE_MS * CLK_KHZ;
    localparam int unsigned BUS_MAX_KHZ = 400;
    localparam int CNT_W = 28;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_AW = 4;
    localparam int MEM_AW = 8;
    localparam int RELEASE_GUARD = 3;
    localparam logic [1:0] SYNC_RST_LOW = 2'h0;
    localparam logic [1:0] SYNC_RST_HIGH = 2'h3;

    typedef enum logic [1:0] {
        SUP_HOLD = 2'b00,
        SUP_TIMEOUT = 2'b01,
        SUP_RUN = 2'b10
    } ssw_sup_state_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_LOAD = 2'b01,
        WR_PROG = 2'b10
    } ssw_wr_state_t;

    typedef struct packed {
        logic vld;
        logic [7:0] data;
    } ssw_byte_t;

    typedef struct packed {
        logic we;
        logic [MEM_AW-1:0] addr;
        logic [7:0] data;
    } ssw_array_wr_t;
endpackage : ssw_pkg

// ==== verilog/ssw_supervisor.sv ====
// Purpose: supply supervisor, watchdog, reset pin and write protection
// Assumes: comparator levels and pins are asynchronous; the two-wire
//          protocol engine sits on clk and hands over whole bytes
// Notes: counts above 4096 cycles are parameters to allow short sims
`timescale 1ns/1ns
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter bit DUAL_RESET = 1'b1,
    parameter bit HAS_WDT = 1'b0,
    parameter int unsigned P_RST_TIMEOUT_CYC = RST_TIMEOUT_CYC,
    parameter int unsigned P_WDT_CYC = WDT_CYC,
    parameter int unsigned P_WRITE_CYCLE_CYC = WRITE_CYCLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // analog comparators
    input wire logic vcc_below_th,
    input wire logic aux_below_ref,
    // reset pins
    input wire logic reset_n_pin_i,
    output logic reset_n_pin_o,
    output logic reset_n_pin_oe,
    output logic reset_hi_o,
    // watchdog
    input wire logic watchdog_kick_input,
    // auxiliary monitor open-drain output
    output logic aux_low_voltage_output_o,
    output logic aux_low_voltage_output_oe,
    // to and from two-wire protocol engine
    input wire logic wr_begin,
    input wire logic [MEM_AW-1:0] wr_addr,
    input wire ssw_byte_t wr_byte,
    input wire logic wr_stop,
    output logic bus_busy,
    output logic wr_blocked,
    // to memory array
    output ssw_array_wr_t array_wr
);
    // synchronisers: first stage read only by second
    logic [1:0] vcc_s_q, aux_s_q, pin_s_q, kick_s_q;
    logic kick_prev_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            // assume supply low until proven otherwise
            vcc_s_q <= SYNC_RST_HIGH;
            aux_s_q <= SYNC_RST_HIGH;
            pin_s_q <= SYNC_RST_HIGH;
            kick_s_q <= SYNC_RST_LOW;
            kick_prev_q <= 1'b0;
        end else begin
            vcc_s_q <= {vcc_s_q[0], vcc_below_th};
            aux_s_q <= {aux_s_q[0], aux_below_ref};
            pin_s_q <= {pin_s_q[0], reset_n_pin_i};
            kick_s_q <= {kick_s_q[0], watchdog_kick_input};
            kick_prev_q <= kick_s_q[1];
        end
    end

    logic vcc_low, kick_edge;
    assign vcc_low = vcc_s_q[1];
    assign kick_edge = kick_s_q[1] ^ kick_prev_q;

    // supervisor state
    ssw_sup_state_t sup_q, sup_d;
    logic [CNT_W-1:0] tmo_q, tmo_d;
    logic [CNT_W-1:0] wdt_q, wdt_d;
    logic [1:0] guard_q, guard_d;
    logic manual, wdt_expire, rst_active;

    assign rst_active = (sup_q != SUP_RUN);
    // own drive reads back low for a few cycles after release
    assign manual = !pin_s_q[1] && !rst_active && (guard_q == 2'h0);
    assign wdt_expire = HAS_WDT && (sup_q == SUP_RUN)
        && !kick_edge && (wdt_q == CNT_W'(P_WDT_CYC - 1));

    always_comb begin
        sup_d = sup_q;
        tmo_d = tmo_q;
        wdt_d = wdt_q;
        guard_d = (guard_q != 2'h0) ? guard_q - 2'h1 : 2'h0;
        unique case (sup_q)
            SUP_HOLD: begin
                tmo_d = '0;
                if (!vcc_low) begin
                    sup_d = SUP_TIMEOUT;
                end
            end
            SUP_TIMEOUT: begin
                tmo_d = tmo_q + CNT_W'(1);
                if (tmo_q == CNT_W'(P_RST_TIMEOUT_CYC - 1)) begin
                    sup_d = SUP_RUN;
                    guard_d = 2'(RELEASE_GUARD);
                end
            end
            SUP_RUN: begin
                if (manual || wdt_expire) begin
                    sup_d = SUP_TIMEOUT;
                    tmo_d = '0;
                end
            end
        endcase
        if (vcc_low) begin
            sup_d = SUP_HOLD;
        end
        // count afresh from the release edge, not one ahead of it
        if (sup_q != SUP_RUN || sup_d != SUP_RUN || kick_edge) begin
            wdt_d = '0;
        end else begin
            wdt_d = wdt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sup_q <= SUP_HOLD;
            tmo_q <= '0;
            wdt_q <= '0;
            guard_q <= 2'h0;
        end else begin
            sup_q <= sup_d;
            tmo_q <= tmo_d;
            wdt_q <= wdt_d;
            guard_q <= guard_d;
        end
    end

    // pins
    assign reset_n_pin_o = 1'b0;
    assign reset_n_pin_oe = rst_active;
    assign reset_hi_o = DUAL_RESET ? rst_active : 1'b0;
    assign aux_low_voltage_output_o = 1'b0;
    assign aux_low_voltage_output_oe = aux_s_q[1];

    // page write path
    ssw_wr_state_t wr_q, wr_d;
    logic [MEM_AW-1:0] base_q, base_d;
    logic [PAGE_AW:0] cnt_q, cnt_d;
    logic [PAGE_AW:0] out_q, out_d;
    logic [CNT_W-1:0] prog_q, prog_d;
    logic rd_vld_q, rd_vld_d;
    logic [MEM_AW-1:0] rd_addr_q, rd_addr_d;
    logic buf_we;
    logic [PAGE_AW-1:0] buf_waddr, buf_raddr;
    logic [7:0] buf_rdata;
    logic [PAGE_AW-1:0] load_idx;

    assign wr_blocked = vcc_low;
    assign bus_busy = (wr_q == WR_PROG);
    assign load_idx = base_q[PAGE_AW-1:0] + cnt_q[PAGE_AW-1:0];
    // rollover inside the page, only the last 16 bytes survive
    assign buf_we = (wr_q == WR_LOAD) && wr_byte.vld && !vcc_low;
    assign buf_waddr = load_idx;
    assign buf_raddr = base_q[PAGE_AW-1:0] + out_q[PAGE_AW-1:0];

    always_comb begin
        wr_d = wr_q;
        base_d = base_q;
        cnt_d = cnt_q;
        out_d = out_q;
        prog_d = prog_q;
        rd_vld_d = 1'b0;
        rd_addr_d = rd_addr_q;
        unique case (wr_q)
            WR_IDLE: begin
                if (wr_begin && !vcc_low) begin
                    wr_d = WR_LOAD;
                    base_d = wr_addr;
                    cnt_d = '0;
                end
            end
            WR_LOAD: begin
                if (buf_we) begin
                    base_d = (cnt_q == (PAGE_AW+1)'(PAGE_BYTES))
                        ? {base_q[MEM_AW-1:PAGE_AW], load_idx + 4'h1}
                        : base_q;
                    if (cnt_q != (PAGE_AW+1)'(PAGE_BYTES)) begin
                        cnt_d = cnt_q + (PAGE_AW+1)'(1);
                    end
                end
                if (vcc_low) begin
                    wr_d = WR_IDLE;
                end else if (wr_stop) begin
                    wr_d = (cnt_q != '0) ? WR_PROG : WR_IDLE;
                    out_d = '0;
                    prog_d = '0;
                end
            end
            WR_PROG: begin
                prog_d = prog_q + CNT_W'(1);
                if (out_q != cnt_q && !vcc_low) begin
                    rd_vld_d = 1'b1;
                    rd_addr_d = {base_q[MEM_AW-1:PAGE_AW], buf_raddr};
                    out_d = out_q + (PAGE_AW+1)'(1);
                end
                if (prog_q == CNT_W'(P_WRITE_CYCLE_CYC - 1)) begin
                    wr_d = WR_IDLE;
                end
            end
            default: wr_d = WR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_q <= WR_IDLE;
            base_q <= '0;
            cnt_q <= '0;
            out_q <= '0;
            prog_q <= '0;
            rd_vld_q <= 1'b0;
            rd_addr_q <= '0;
        end else begin
            wr_q <= wr_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            prog_q <= prog_d;
            rd_vld_q <= rd_vld_d;
            rd_addr_q <= rd_addr_d;
        end
    end

    // array write address and data come straight from registers; we is rd_vld_q gated by vcc_low
    always_comb begin
        array_wr.we = rd_vld_q && !vcc_low;
        array_wr.addr = rd_addr_q;
        array_wr.data = buf_rdata;
    end

    ssw_page_buf u_buf (
        .clk(clk),
        .we(buf_we),
        .waddr(buf_waddr),
        .wdata(wr_byte.data),
        .raddr(buf_raddr),
        .rdata(buf_rdata)
    );
endmodule : ssw_supervisor
